// ===== design/pin_cell_regs.svh
`ifndef PIN_CELL_REGS_SVH
`define PIN_CELL_REGS_SVH

// Register byte addresses
`define ADDR_CONFIG 12'h000
`define ADDR_DIVIDER 12'h004
`define ADDR_STATUS 12'h008

// Configuration field positions
`define CFG_MODE_LO 0
`define CFG_MODE_HI 1
`define CFG_CLR_EN 2
`define CFG_PWR_IN 3
`define CFG_PWR_OUT 4
`define CFG_PWR_OE 5
`define CFG_DLY_LO 6
`define CFG_DLY_HI 7
`define CFG_IN_FALL 8
`define CFG_MSB 8

// Mode field codes
`define MODE_CODE_SDR 2'h0
`define MODE_CODE_DDR_IN 2'h1
`define MODE_CODE_DDR_OUT 2'h2

// Input delay settings
`define DLY_OFF 2'h0
`define DLY_ONE 2'h1
`define DLY_TWO 2'h2
`define DLY_THREE 2'h3

// Status field positions
`define ST_IN 0
`define ST_OE 1
`define ST_OUT 2
`define ST_PHASE 3
`define ST_PIN 4

// Reset values
`define CFG_RESET 9'h000
`define DIV_RESET 8'h00
`define DIV_MSB 7
`define WARM_FULL 2'h3

`endif

// ===== design/pin_cell_pkg.sv
package pin_cell_pkg;

  // Operating modes of the cell
  typedef enum logic [2:0] {
    MODE_SDR = 3'b001,
    MODE_DDR_IN = 3'b010,
    MODE_DDR_OUT = 3'b100
  } mode_t;

  // Configuration word, bit 0 at the bottom
  typedef struct packed {
    logic in_fall;
    logic [1:0] dly_sel;
    logic pwr_oe;
    logic pwr_out;
    logic pwr_in;
    logic clr_en;
    logic [1:0] mode_code;
  } cfg_t;

  // Core-side request bundle
  typedef struct packed {
    logic d0;
    logic d1;
    logic oe;
    logic ce_in;
    logic ce_out;
    logic ce_oe;
    logic clr;
  } core_req_t;

  typedef logic [1:0] dly_sel_t;

endpackage

// ===== design/pin_cell_reg.sv
`include "pin_cell_regs.svh"

module pin_cell_reg (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Shared clear or preset
  input wire logic clr,
  input wire logic clr_en,
  input wire logic pwr_hi,
  // Data path
  input wire logic en,
  input wire logic d,
  output logic q
);
  import pin_cell_pkg::*;

  // Clear or preset to the power-up level, else load on enable
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= pwr_hi;
    end else if (clr && clr_en) begin
      q <= pwr_hi;
    end else if (en) begin
      q <= d;
    end
  end

  AST_CLR_LEVEL: assert property (@(posedge clk) disable iff (rst)
    (clr && clr_en) |=> (q == $past(pwr_hi)))
    else $error("register missed its clear or preset level");

endmodule

// ===== design/input_delay.sv
`include "pin_cell_regs.svh"

module input_delay (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Delay setting
  input wire pin_cell_pkg::dly_sel_t sel,
  // Data path
  input wire logic din,
  output logic dout
);
  import pin_cell_pkg::*;

  logic [2:0] stage_q;
  logic [1:0] warm_q;

  // Delay chain, one cycle a stage
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_q <= 3'h0;
    end else begin
      stage_q <= {stage_q[1:0], din};
    end
  end

  // Counts cycles since reset, stopping at three, for checking
  always_ff @(posedge clk) begin
    if (rst) begin
      warm_q <= 2'h0;
    end else if (warm_q != `WARM_FULL) begin
      warm_q <= warm_q + 2'h1;
    end
  end

  // Tap select: bypass or one of three delays
  always_comb begin
    dout = din;
    if (sel == `DLY_ONE) begin
      dout = stage_q[0];
    end else if (sel == `DLY_TWO) begin
      dout = stage_q[1];
    end else if (sel == `DLY_THREE) begin
      dout = stage_q[2];
    end
  end

  AST_DLY_DEEPEST: assert property (@(posedge clk) disable iff (rst)
    (sel == `DLY_THREE && warm_q == `WARM_FULL)
    |-> (dout == $past(din, 3)))
    else $error("deepest input delay is not three cycles");

  AST_DLY_BYPASS: assert property (@(posedge clk) disable iff (rst)
    (sel == `DLY_OFF) |-> (dout == din))
    else $error("bypassed input delay adds latency");

endmodule

// ===== design/pin_io_cell.sv
`include "pin_cell_regs.svh"

module pin_io_cell (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Core side
  input wire pin_cell_pkg::core_req_t CORE_REQ,
  output logic CORE_Q_IN,
  output logic CORE_Q_OE,
  output logic CORE_PIN_RAW,
  // Pin side
  input wire logic PIN_I,
  output logic PIN_O,
  output logic PIN_OE,
  output logic CELL_CLK
);
  import pin_cell_pkg::*;

  cfg_t cfg_q;
  logic [`DIV_MSB:0] div_q;
  logic [`DIV_MSB:0] div_cnt_q;
  logic phase_q;
  logic tick;
  logic rise;
  logic fall;
  mode_t mode;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_dly;
  logic raw_q;
  logic latch_q;
  logic in_q;
  logic out_q;
  logic oe_q;
  logic in_edge;
  logic oe_d;
  logic pin_o_q;
  logic pin_oe_q;
  logic clr_act;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic apb_wr;
  logic apb_setup;

  // Bus strobes
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_setup = PSEL && !PENABLE;
  assign PREADY = 1'b1;
  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q;

  // Configuration register
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cfg_q <= `CFG_RESET;
    end else if (apb_wr && PADDR == `ADDR_CONFIG) begin
      cfg_q <= cfg_t'(PWDATA[`CFG_MSB:0]);
    end
  end

  // Cell clock divider setting
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      div_q <= `DIV_RESET;
    end else if (apb_wr && PADDR == `ADDR_DIVIDER) begin
      div_q <= PWDATA[`DIV_MSB:0];
    end
  end

  // Read data and error, prepared in the setup cycle
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      if (PADDR == `ADDR_CONFIG) begin
        prdata_q[`CFG_MSB:0] <= cfg_q;
      end else if (PADDR == `ADDR_DIVIDER) begin
        prdata_q[`DIV_MSB:0] <= div_q;
      end else if (PADDR == `ADDR_STATUS) begin
        prdata_q[`ST_IN] <= in_q;
        prdata_q[`ST_OE] <= oe_q;
        prdata_q[`ST_OUT] <= out_q;
        prdata_q[`ST_PHASE] <= phase_q;
        prdata_q[`ST_PIN] <= pin_s2_q;
      end else begin
        pslverr_q <= 1'b1;
      end
    end
  end

  // Mode decode from the configuration field
  always_comb begin
    case (cfg_q.mode_code)
      `MODE_CODE_DDR_IN: mode = MODE_DDR_IN;
      `MODE_CODE_DDR_OUT: mode = MODE_DDR_OUT;
      default: mode = MODE_SDR;
    endcase
  end

  // Cell clock: phase toggles once per divider period
  assign tick = (div_cnt_q == div_q);
  assign rise = tick && !phase_q;
  assign fall = tick && phase_q;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      div_cnt_q <= `DIV_RESET;
    end else if (tick) begin
      div_cnt_q <= `DIV_RESET;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      phase_q <= 1'b0;
    end else if (tick) begin
      phase_q <= !phase_q;
    end
  end

  assign CELL_CLK = phase_q;

  // Pin synchroniser
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= PIN_I;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Programmable input delay
  input_delay u_delay (
    .clk(MCLK),
    .rst(SYS_RST),
    .sel(cfg_q.dly_sel),
    .din(pin_s2_q),
    .dout(pin_dly)
  );

  // Pin value registered one cycle after the input delay, for core capture of DDR reads
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= pin_dly;
    end
  end

  assign CORE_PIN_RAW = raw_q;

  // Input latch, transparent while the cell clock is high in DDR input mode
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      latch_q <= 1'b0;
    end else if (mode == MODE_DDR_IN && phase_q) begin
      latch_q <= pin_dly;
    end
  end

  // Input register may take the falling edge in single-rate use
  assign in_edge = (mode == MODE_SDR && cfg_q.in_fall) ? fall : rise;

  // Enable register data source per mode
  always_comb begin
    case (mode)
      MODE_DDR_IN: oe_d = latch_q;
      MODE_DDR_OUT: oe_d = CORE_REQ.d1;
      default: oe_d = CORE_REQ.oe;
    endcase
  end

  assign clr_act = CORE_REQ.clr && cfg_q.clr_en;

  // Input register
  pin_cell_reg u_in_reg (
    .clk(MCLK),
    .rst(SYS_RST),
    .clr(CORE_REQ.clr),
    .clr_en(cfg_q.clr_en),
    .pwr_hi(cfg_q.pwr_in),
    .en(in_edge && CORE_REQ.ce_in),
    .d(pin_dly),
    .q(in_q)
  );

  // Output register, on the shared rising edge
  pin_cell_reg u_out_reg (
    .clk(MCLK),
    .rst(SYS_RST),
    .clr(CORE_REQ.clr),
    .clr_en(cfg_q.clr_en),
    .pwr_hi(cfg_q.pwr_out),
    .en(rise && CORE_REQ.ce_out),
    .d(CORE_REQ.d0),
    .q(out_q)
  );

  // Enable register, same edge as the output register
  pin_cell_reg u_oe_reg (
    .clk(MCLK),
    .rst(SYS_RST),
    .clr(CORE_REQ.clr),
    .clr_en(cfg_q.clr_en),
    .pwr_hi(cfg_q.pwr_oe),
    .en(rise && CORE_REQ.ce_oe),
    .d(oe_d),
    .q(oe_q)
  );

  assign CORE_Q_IN = in_q;
  assign CORE_Q_OE = oe_q;

  // Pin drive: DDR output mux by clock level, else registered data
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      case (mode)
        MODE_DDR_OUT: begin
          pin_o_q <= phase_q ? out_q : oe_q;
          pin_oe_q <= 1'b1;
        end
        MODE_DDR_IN: begin
          pin_o_q <= out_q;
          pin_oe_q <= 1'b0;
        end
        default: begin
          pin_o_q <= out_q;
          pin_oe_q <= oe_q;
        end
      endcase
    end
  end

  assign PIN_O = pin_o_q;
  assign PIN_OE = pin_oe_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  AST_SDR_ENABLE: assert property ((mode == MODE_SDR) |=>
    (PIN_OE == $past(oe_q) && PIN_O == $past(out_q)))
    else $error("single-rate pin not driven by its registers");

  AST_SHARED_EDGE: assert property (($changed(out_q) || $changed(oe_q))
    |-> ($past(rise) || $past(clr_act)))
    else $error("output or enable register moved off the shared edge");

  AST_SDR_IN_FALL: assert property ((mode == MODE_SDR &&
    cfg_q.in_fall && fall && CORE_REQ.ce_in && !clr_act) |=>
    (in_q == $past(pin_dly)))
    else $error("input register missed the falling cell edge");

  AST_SDR_IN_RISE: assert property ((mode == MODE_SDR &&
    !cfg_q.in_fall && rise && CORE_REQ.ce_in && !clr_act) |=>
    (in_q == $past(pin_dly)))
    else $error("input register missed the rising cell edge");

  AST_CE_HOLD: assert property ((!clr_act && !CORE_REQ.ce_oe) |=>
    $stable(oe_q))
    else $error("enable register changed with its enable low");

  AST_IN_HOLD: assert property ((!clr_act && !CORE_REQ.ce_in) |=>
    $stable(in_q))
    else $error("input register changed with its enable low");

  AST_OUT_HOLD: assert property ((!clr_act && !CORE_REQ.ce_out) |=>
    $stable(out_q))
    else $error("output register changed with its enable low");

  AST_CLR_UNUSED: assert property ((!cfg_q.clr_en && !CORE_REQ.ce_out)
    |=> $stable(out_q))
    else $error("clear acted on a cell with clear unused");

  AST_CLR_PRESET: assert property (clr_act |=>
    (in_q == $past(cfg_q.pwr_in) && oe_q == $past(cfg_q.pwr_oe)))
    else $error("clear did not restore power-up levels");

  AST_DDR_IN_BOTH: assert property ((mode == MODE_DDR_IN && rise &&
    CORE_REQ.ce_in && CORE_REQ.ce_oe && !clr_act) |=>
    (in_q == $past(pin_dly) && oe_q == $past(latch_q)))
    else $error("DDR input bits not captured on one edge");

  AST_DDR_IN_FLOAT: assert property ((mode == MODE_DDR_IN) |=>
    !PIN_OE)
    else $error("buffer driven during DDR input");

  AST_LATCH_HIGH: assert property ((mode == MODE_DDR_IN && phase_q)
    |=> (latch_q == $past(pin_dly)))
    else $error("input latch not transparent in high phase");

  AST_LATCH_HOLD: assert property ((mode == MODE_DDR_IN && !phase_q)
    |=> $stable(latch_q))
    else $error("input latch moved in low phase");

  AST_DDR_OUT_LOAD: assert property ((mode == MODE_DDR_OUT && rise &&
    CORE_REQ.ce_oe && CORE_REQ.ce_out && !clr_act) |=>
    (oe_q == $past(CORE_REQ.d1) && out_q == $past(CORE_REQ.d0)))
    else $error("DDR output bits not loaded on rising edge");

  AST_DDR_OUT_HI: assert property ((mode == MODE_DDR_OUT && phase_q)
    |=> (PIN_O == $past(out_q)))
    else $error("pin lost output bit in high phase");

  AST_DDR_OUT_LO: assert property ((mode == MODE_DDR_OUT && !phase_q)
    |=> (PIN_O == $past(oe_q)))
    else $error("pin lost enable bit in low phase");

  AST_OE_FORCED: assert property ((mode == MODE_DDR_OUT) |=>
    PIN_OE)
    else $error("buffer released during DDR output");

  AST_RAW_PATH: assert property (1'b1 |=>
    (CORE_PIN_RAW == $past(pin_dly)))
    else $error("raw pin path to core broken");

  // Cover points for the main scenarios
  CV_DDR_OUT: cover property ((mode == MODE_DDR_OUT && rise) ##[1:256]
    fall);
  CV_SDR_FALL: cover property (mode == MODE_SDR && cfg_q.in_fall && fall &&
    CORE_REQ.ce_in);
  CV_DDR_IN: cover property (mode == MODE_DDR_IN && rise &&
    CORE_REQ.ce_in && CORE_REQ.ce_oe);
  CV_CLEAR: cover property (clr_act ##1 !clr_act);

endmodule

// ===== testbench/pin_partner.sv
module pin_partner (
  // Clocks
  input wire logic clk,
  input wire logic cell_clk,
  // Bits sent in each cell clock phase
  input wire logic hi_bit,
  input wire logic lo_bit,
  // Pin wire
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_q;

  // Far device launches one bit per cell clock phase
  always_ff @(posedge clk) begin
    drv_q <= cell_clk ? hi_bit : lo_bit;
  end

  // Wire level: cell drives when enabled, else the far device
  assign pin_i = pin_oe ? pin_o : drv_q;
endmodule

// ===== testbench/ddr_capable_pin_io_cell_test.sv
`include "pin_cell_regs.svh"

module ddr_capable_pin_io_cell_test;
  import pin_cell_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, CORE_Q_IN, CORE_Q_OE, CORE_PIN_RAW;
  logic PIN_I, PIN_O, PIN_OE, CELL_CLK;
  core_req_t CORE_REQ = '0;
  logic hi_bit = 1'b0;
  logic lo_bit = 1'b0;
  logic prev_clk;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int checks = 0;

  // Clock generator
  always #10 MCLK = ~MCLK;

  pin_io_cell u_dut (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CORE_REQ(CORE_REQ),
    .CORE_Q_IN(CORE_Q_IN), .CORE_Q_OE(CORE_Q_OE),
    .CORE_PIN_RAW(CORE_PIN_RAW), .PIN_I(PIN_I), .PIN_O(PIN_O),
    .PIN_OE(PIN_OE), .CELL_CLK(CELL_CLK)
  );

  pin_partner u_far (
    .clk(MCLK), .cell_clk(CELL_CLK), .hi_bit(hi_bit), .lo_bit(lo_bit),
    .pin_o(PIN_O), .pin_oe(PIN_OE), .pin_i(PIN_I)
  );

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One APB transfer, result in rd and err
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1 && n < 20) begin
      n++;
      @(posedge MCLK);
    end
    if (n == 20) begin
      errors++;
      end_sim();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic put(input core_req_t v);
    @(posedge MCLK);
    CORE_REQ <= v;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge MCLK);
    @(negedge MCLK);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(negedge MCLK);
    chk(CORE_Q_IN, 1'b0);
    apb(1'b0, `ADDR_CONFIG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, `ADDR_CONFIG, 32'h1FF);
    apb(1'b0, `ADDR_CONFIG, 32'h0);
    chk(rd, 32'h1FF);
    // Single rate, then hold output while enable reg updates
    apb(1'b1, `ADDR_CONFIG, 32'h0);
    apb(1'b1, `ADDR_DIVIDER, 32'h3);
    put(7'h5E);
    settle(30);
    chk(PIN_O, 1'b1);
    chk(PIN_OE, 1'b1);
    put(7'h0A);
    settle(30);
    chk(PIN_O, 1'b1);
    chk(PIN_OE, 1'b0);
    // Shared clear: preset, ignored, then clear
    put(7'h01);
    apb(1'b1, `ADDR_CONFIG, 32'h14);
    settle(4);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd[2:1], 2'h2);
    apb(1'b1, `ADDR_CONFIG, 32'h0);
    settle(4);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd[2], 1'b1);
    apb(1'b1, `ADDR_CONFIG, 32'h04);
    settle(4);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd[2], 1'b0);
    // Double rate output, both bit orders
    apb(1'b1, `ADDR_CONFIG, 32'h2);
    for (int p = 0; p < 2; p++) begin
      put(p == 0 ? 7'h4E : 7'h2E);
      settle(20);
      prev_clk = CELL_CLK;
      repeat (16) begin
        @(negedge MCLK);
        chk(PIN_O, prev_clk ^ p[0]);
        chk(PIN_OE, 1'b1);
        prev_clk = CELL_CLK;
      end
    end
    // Double rate input at every delay setting
    apb(1'b1, `ADDR_DIVIDER, 32'h7);
    put(7'h0A);
    for (int d = 0; d < 4; d++) begin
      for (int h = 0; h < 2; h++) begin
        apb(1'b1, `ADDR_CONFIG, {24'h0, d[1:0], 6'h01});
        @(posedge MCLK);
        hi_bit <= h[0];
        lo_bit <= ~h[0];
        settle(40);
        chk(CORE_Q_IN, !h[0]);
        chk(CORE_Q_OE, h[0]);
        chk(PIN_OE, 1'b0);
      end
    end
    // Single rate input on the falling cell edge, raw path to core
    apb(1'b1, `ADDR_CONFIG, 32'h100);
    for (int v = 0; v < 2; v++) begin
      @(posedge MCLK);
      hi_bit <= v[0];
      lo_bit <= v[0];
      settle(40);
      chk(CORE_Q_IN, v[0]);
      chk(CORE_PIN_RAW, v[0]);
      chk(PIN_OE, 1'b0);
    end
    end_sim();
  end
endmodule
